// ==== sod_decoder.sv ====
// Purpose: Byte-serial instruction decoder for a stack intermediate-code machine
// Assumes: Fetch unit offers one byte per cycle with a valid strobe
// Notes:   Result is a one-cycle pulse; parameters collected before it fires
`timescale 1ns/1ps
`default_nettype none
`include "sod_regs.svh"

module sod_decoder #(
  parameter int unsigned MAX_PARAMS = 4
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 nrst_i,
  // Byte stream from fetch unit
  input  wire logic                 byte_valid_i,
  input  wire logic [7:0]           byte_i,
  // Decode result to sequencer
  output logic                      done_o,
  output sod_pkg::sod_opclass_t     opclass_o,
  output logic [7:0]                opcode_o,
  output logic                      illegal_o,
  output logic                      real_trap_en_o,
  output logic [2:0]                nparams_o,
  output logic [11:0]               kinds_o,
  output logic [15:0]               param0_o,
  output logic [15:0]               param1_o,
  output logic [15:0]               param2_o,
  output logic [15:0]               param3_o,
  // Pending information to fetch unit
  output logic                      busy_o,
  output logic [2:0]                pending_o,
  output sod_pkg::sod_pkind_t       next_kind_o
);
  import sod_pkg::*;

  // Slot logic below is written for exactly four parameter words
  if (MAX_PARAMS != 4) begin : g_bad_params
    $error("sod_decoder supports exactly four parameter slots");
  end

  // Table lookup on the incoming byte
  sod_opclass_t tbl_class;
  logic [2:0]   tbl_n;
  sod_pkind_t   tbl_k0, tbl_k1, tbl_k2, tbl_k3;

  sod_opcode_table u_table (
    .opcode_i  (byte_i),
    .opclass_o (tbl_class),
    .nparams_o (tbl_n),
    .kind0_o   (tbl_k0),
    .kind1_o   (tbl_k1),
    .kind2_o   (tbl_k2),
    .kind3_o   (tbl_k3)
  );

  // Held instruction
  sod_state_t   state;
  sod_opclass_t cls;
  logic [7:0]   opc;
  logic [2:0]   total;
  logic [2:0]   idx;
  logic [11:0]  kinds;
  logic [7:0]   first;
  logic [15:0]  params [0:3];

  function automatic sod_pkind_t kind_at(input logic [11:0] k, input logic [2:0] i);
    kind_at = sod_pkind_t'(k[3*i[1:0] +: 3]);
  endfunction

  function automatic logic is_real_arith(input sod_opclass_t c);
    is_real_arith = (c == SOD_OC_REAL_ADD) || (c == SOD_OC_REAL_SUBTRACT) ||
                    (c == SOD_OC_REAL_MULTIPLY) || (c == SOD_OC_REAL_DIVIDE);
  endfunction

  wire sod_pkind_t cur_kind = kind_at(kinds, idx);
  wire logic [11:0] tbl_kinds = {tbl_k3, tbl_k2, tbl_k1, tbl_k0};

  // Widening; single-byte kinds finish in FIRST, two-byte ones in SECOND
  logic [15:0] wide_one, wide_two;
  logic        need_two;

  sod_param_widen u_widen_one (
    .kind_i   (cur_kind),
    .first_i  (byte_i),
    .second_i (8'h00),
    .word_o   (wide_one),
    .two_o    (need_two)
  );

  sod_param_widen u_widen_two (
    .kind_i   (cur_kind),
    .first_i  (first),
    .second_i (byte_i),
    .word_o   (wide_two),
    .two_o    ()
  );

  wire logic take_op    = byte_valid_i && (state == SOD_ST_OPCODE);
  wire logic take_first = byte_valid_i && (state == SOD_ST_FIRST);
  wire logic take_sec   = byte_valid_i && (state == SOD_ST_SECOND);
  wire logic param_end  = (take_first && !need_two) || take_sec;
  wire logic last_param = param_end && (idx == total - 3'h1);
  wire logic finish     = (take_op && tbl_n == 3'h0) || last_param;
  wire logic [15:0] last_word = take_sec ? wide_two : wide_one;
  // Held slots clear only on the opcode edge, so a nullary opcode must not show them
  wire logic [3:0]  slot_hit  = last_param ? (4'h1 << idx[1:0]) : 4'h0;

  sod_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      SOD_ST_OPCODE: if (take_op && tbl_n != 3'h0) next_state = SOD_ST_FIRST;
      SOD_ST_FIRST:  if (take_first) next_state = need_two ? SOD_ST_SECOND :
                                            (last_param ? SOD_ST_OPCODE : SOD_ST_FIRST);
      SOD_ST_SECOND: if (take_sec) next_state = last_param ? SOD_ST_OPCODE : SOD_ST_FIRST;
      default:       next_state = SOD_ST_OPCODE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state <= SOD_ST_OPCODE;
      cls   <= SOD_OC_ILLEGAL;
      opc   <= 8'h00;
      total <= 3'h0;
      idx   <= 3'h0;
      kinds <= 12'h000;
      first <= 8'h00;
      for (int i = 0; i < 4; i++) params[i] <= `SOD_RESET_WORD;
    end else begin
      state <= next_state;
      if (take_op) begin
        cls   <= tbl_class;
        opc   <= byte_i;
        total <= tbl_n;
        kinds <= tbl_kinds;
        idx   <= 3'h0;
        for (int i = 0; i < 4; i++) params[i] <= `SOD_RESET_WORD;
      end
      if (take_first) first <= byte_i;
      if (take_first && !need_two) params[idx[1:0]] <= wide_one;
      if (take_sec) params[idx[1:0]] <= wide_two;
      if (param_end) idx <= idx + 3'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      done_o         <= 1'b0;
      opclass_o      <= SOD_OC_ILLEGAL;
      opcode_o       <= 8'h00;
      illegal_o      <= 1'b0;
      real_trap_en_o <= 1'b0;
      nparams_o      <= 3'h0;
      kinds_o        <= 12'h000;
      param0_o       <= `SOD_RESET_WORD;
      param1_o       <= `SOD_RESET_WORD;
      param2_o       <= `SOD_RESET_WORD;
      param3_o       <= `SOD_RESET_WORD;
      busy_o         <= 1'b0;
      pending_o      <= 3'h0;
      next_kind_o    <= SOD_PK_NONE;
    end else begin
      done_o <= finish;
      if (finish) begin
        opclass_o      <= take_op ? tbl_class : cls;
        opcode_o       <= take_op ? byte_i : opc;
        illegal_o      <= take_op ? (tbl_class == SOD_OC_ILLEGAL) : 1'b0;
        real_trap_en_o <= take_op ? is_real_arith(tbl_class) : is_real_arith(cls);
        nparams_o      <= take_op ? tbl_n : total;
        kinds_o        <= take_op ? tbl_kinds : kinds;
        param0_o       <= take_op ? `SOD_RESET_WORD : (slot_hit[0] ? last_word : params[0]);
        param1_o       <= take_op ? `SOD_RESET_WORD : (slot_hit[1] ? last_word : params[1]);
        param2_o       <= take_op ? `SOD_RESET_WORD : (slot_hit[2] ? last_word : params[2]);
        param3_o       <= take_op ? `SOD_RESET_WORD : (slot_hit[3] ? last_word : params[3]);
      end
      busy_o      <= (next_state != SOD_ST_OPCODE);
      pending_o   <= take_op ? tbl_n : (finish ? 3'h0 : total - idx - {2'b00, param_end});
      next_kind_o <= take_op ? tbl_k0 :
                     (finish ? SOD_PK_NONE : kind_at(kinds, idx + {2'b00, param_end}));
    end
  end

  // Checks
  a_nullary_done: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take_op && (byte_i == `SOD_OP_SWAP_TOP) |=> done_o && nparams_o == 3'h0)
    else $error("swap opcode did not finish in one cycle");
  a_unsigned_cmp: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take_op && (byte_i == `SOD_OP_UNSIGNED_LE) |=> opclass_o == SOD_OC_UNSIGNED_LE)
    else $error("unsigned le compare misdecoded");
  a_int_negate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take_op && (byte_i == `SOD_OP_INTEGER_NEGATE) |=>
      done_o && opclass_o == SOD_OC_INTEGER_NEGATE)
    else $error("integer negate misdecoded");
  a_illegal_flag: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    done_o && illegal_o |-> opclass_o == SOD_OC_ILLEGAL && nparams_o == 3'h0)
    else $error("illegal flag with defined class");
  a_real_trap: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    take_op && (byte_i == `SOD_OP_REAL_MULTIPLY) |=> real_trap_en_o)
    else $error("real multiply lacks trap enable");
  sequence s_jump_two;
    take_op && byte_i == `SOD_OP_JUMP_ALWAYS ##1 byte_valid_i && byte_i == 8'hFE;
  endsequence
  a_jump_sign: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_jump_two |=> done_o && param0_o == 16'hFFFE)
    else $error("jump displacement not sign extended");
  sequence s_call_ext;
    take_op && byte_i == `SOD_OP_CALL_EXT_GLOBAL ##1 take_first ##1 take_first;
  endsequence
  a_call_two_ub: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_call_ext |=> done_o && nparams_o == 3'h2 && param1_o[15:8] == 8'h00)
    else $error("external call params wrong");
  sequence s_big_long;
    take_op && byte_i == `SOD_OP_RETURN_USER_PROC ##1 take_first && byte_i == 8'h81
      ##1 byte_valid_i && byte_i == 8'h23;
  endsequence
  a_big_pair: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_big_long |=> done_o && param0_o == 16'h0123)
    else $error("big parameter misassembled");
  a_count_bound: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    done_o |-> nparams_o <= `SOD_MAX_PARAMS)
    else $error("too many parameters");

endmodule
`default_nettype wire

// ==== sod_regs.svh ====
// Purpose: Opcode values, parameter limits and sizes for the stack opcode decoder
// Assumes: One-byte opcodes, at most four inline parameters
// Notes:   Definitions only
`ifndef SOD_REGS_SVH
`define SOD_REGS_SVH

`define SOD_OP_JUMP_ALWAYS        8'h8A
`define SOD_OP_CALL_EXT_LOCAL     8'h93
`define SOD_OP_CALL_EXT_GLOBAL    8'h94
`define SOD_OP_CALL_EXT_INTERM    8'h95
`define SOD_OP_RETURN_USER_PROC   8'h96
`define SOD_OP_PUSH_STATIC_LINK   8'h99
`define SOD_OP_UNSIGNED_LE        8'hB4
`define SOD_OP_UNSIGNED_GE        8'hB5
`define SOD_OP_SET_SUBSET         8'hB7
`define SOD_OP_SET_SUPERSET       8'hB8
`define SOD_OP_BYTES_EQUAL        8'hB9
`define SOD_OP_BYTES_LE           8'hBA
`define SOD_OP_BYTES_GE           8'hBB
`define SOD_OP_SWAP_TOP           8'hBD
`define SOD_OP_REAL_ADD           8'hC0
`define SOD_OP_REAL_SUBTRACT      8'hC1
`define SOD_OP_REAL_MULTIPLY      8'hC2
`define SOD_OP_REAL_DIVIDE        8'hC3
`define SOD_OP_STORE_PACKED       8'hCA
`define SOD_OP_SUBRANGE_CHECK     8'hCB
`define SOD_OP_JUMP_FALSE_EQ      8'hD2
`define SOD_OP_JUMP_FALSE_NE      8'hD3
`define SOD_OP_INTEGER_ABSOLUTE   8'hE0
`define SOD_OP_INTEGER_NEGATE     8'hE1
`define SOD_OP_REAL_ABSOLUTE      8'hE3

`define SOD_MAX_PARAMS            3'h4
`define SOD_BIG_SHORT_LIMIT       8'h7F
`define SOD_SIGN_BIT              7
`define SOD_RESET_WORD            16'h0000

`endif

// ==== sod_pkg.sv ====
// Purpose: Types shared by the stack opcode decoder files
// Assumes: Constants live in sod_regs.svh
// Notes:   Parameter kinds travel as a 3-bit code per slot
package sod_pkg;

  typedef enum logic [2:0] {
    SOD_PK_NONE      = 3'b000,
    SOD_PK_UNSIGNED  = 3'b001,
    SOD_PK_SIGNED    = 3'b010,
    SOD_PK_DONT_CARE = 3'b011,
    SOD_PK_BIG       = 3'b100,
    SOD_PK_WORD      = 3'b101
  } sod_pkind_t;

  typedef enum logic [4:0] {
    SOD_OC_ILLEGAL           = 5'h00,
    SOD_OC_UNSIGNED_LE       = 5'h01,
    SOD_OC_UNSIGNED_GE       = 5'h02,
    SOD_OC_INTEGER_ABSOLUTE  = 5'h03,
    SOD_OC_INTEGER_NEGATE    = 5'h04,
    SOD_OC_SUBRANGE_CHECK    = 5'h05,
    SOD_OC_REAL_ABSOLUTE     = 5'h06,
    SOD_OC_SET_SUBSET        = 5'h07,
    SOD_OC_SET_SUPERSET      = 5'h08,
    SOD_OC_BYTES_EQUAL       = 5'h09,
    SOD_OC_BYTES_LE          = 5'h0A,
    SOD_OC_BYTES_GE          = 5'h0B,
    SOD_OC_JUMP_ALWAYS       = 5'h0C,
    SOD_OC_JUMP_FALSE_EQ     = 5'h0D,
    SOD_OC_JUMP_FALSE_NE     = 5'h0E,
    SOD_OC_CALL_EXT_LOCAL    = 5'h0F,
    SOD_OC_CALL_EXT_GLOBAL   = 5'h10,
    SOD_OC_CALL_EXT_INTERM   = 5'h11,
    SOD_OC_RETURN_USER_PROC  = 5'h12,
    SOD_OC_PUSH_STATIC_LINK  = 5'h13,
    SOD_OC_SWAP_TOP          = 5'h14,
    SOD_OC_STORE_PACKED      = 5'h15,
    SOD_OC_REAL_ADD          = 5'h16,
    SOD_OC_REAL_SUBTRACT     = 5'h17,
    SOD_OC_REAL_MULTIPLY     = 5'h18,
    SOD_OC_REAL_DIVIDE       = 5'h19
  } sod_opclass_t;

  typedef enum logic [1:0] {
    SOD_ST_OPCODE = 2'b00,
    SOD_ST_FIRST  = 2'b01,
    SOD_ST_SECOND = 2'b10
  } sod_state_t;

endpackage

// ==== sod_opcode_table.sv ====
// Purpose: Pure lookup of operation class and parameter kinds per opcode
// Assumes: Combinational; no clock
// Notes:   Unlisted opcodes come out illegal with no parameters
`timescale 1ns/1ps
`default_nettype none
`include "sod_regs.svh"

module sod_opcode_table (
  // Opcode in
  input  wire logic [7:0]           opcode_i,
  // Decode out
  output sod_pkg::sod_opclass_t     opclass_o,
  output logic [2:0]                nparams_o,
  output sod_pkg::sod_pkind_t       kind0_o,
  output sod_pkg::sod_pkind_t       kind1_o,
  output sod_pkg::sod_pkind_t       kind2_o,
  output sod_pkg::sod_pkind_t       kind3_o
);
  import sod_pkg::*;

  always_comb begin
    opclass_o = SOD_OC_ILLEGAL;
    nparams_o = 3'h0;
    kind0_o   = SOD_PK_NONE;
    kind1_o   = SOD_PK_NONE;
    kind2_o   = SOD_PK_NONE;
    kind3_o   = SOD_PK_NONE;
    case (opcode_i)
      `SOD_OP_UNSIGNED_LE:      opclass_o = SOD_OC_UNSIGNED_LE;
      `SOD_OP_UNSIGNED_GE:      opclass_o = SOD_OC_UNSIGNED_GE;
      `SOD_OP_INTEGER_ABSOLUTE: opclass_o = SOD_OC_INTEGER_ABSOLUTE;
      `SOD_OP_INTEGER_NEGATE:   opclass_o = SOD_OC_INTEGER_NEGATE;
      `SOD_OP_SUBRANGE_CHECK:   opclass_o = SOD_OC_SUBRANGE_CHECK;
      `SOD_OP_REAL_ABSOLUTE:    opclass_o = SOD_OC_REAL_ABSOLUTE;
      `SOD_OP_REAL_ADD:         opclass_o = SOD_OC_REAL_ADD;
      `SOD_OP_REAL_SUBTRACT:    opclass_o = SOD_OC_REAL_SUBTRACT;
      `SOD_OP_REAL_MULTIPLY:    opclass_o = SOD_OC_REAL_MULTIPLY;
      `SOD_OP_REAL_DIVIDE:      opclass_o = SOD_OC_REAL_DIVIDE;
      `SOD_OP_SET_SUBSET:       opclass_o = SOD_OC_SET_SUBSET;
      `SOD_OP_SET_SUPERSET:     opclass_o = SOD_OC_SET_SUPERSET;
      `SOD_OP_SWAP_TOP:         opclass_o = SOD_OC_SWAP_TOP;
      `SOD_OP_STORE_PACKED:     opclass_o = SOD_OC_STORE_PACKED;
      `SOD_OP_BYTES_EQUAL, `SOD_OP_BYTES_LE, `SOD_OP_BYTES_GE: begin
        opclass_o = (opcode_i == `SOD_OP_BYTES_EQUAL) ? SOD_OC_BYTES_EQUAL :
                    (opcode_i == `SOD_OP_BYTES_LE) ? SOD_OC_BYTES_LE : SOD_OC_BYTES_GE;
        nparams_o = 3'h1;
        kind0_o   = SOD_PK_BIG;
      end
      `SOD_OP_JUMP_ALWAYS, `SOD_OP_JUMP_FALSE_EQ, `SOD_OP_JUMP_FALSE_NE: begin
        opclass_o = (opcode_i == `SOD_OP_JUMP_ALWAYS) ? SOD_OC_JUMP_ALWAYS :
                    (opcode_i == `SOD_OP_JUMP_FALSE_EQ) ? SOD_OC_JUMP_FALSE_EQ
                                                          : SOD_OC_JUMP_FALSE_NE;
        nparams_o = 3'h1;
        kind0_o   = SOD_PK_SIGNED;
      end
      `SOD_OP_CALL_EXT_LOCAL, `SOD_OP_CALL_EXT_GLOBAL: begin
        opclass_o = (opcode_i == `SOD_OP_CALL_EXT_LOCAL) ? SOD_OC_CALL_EXT_LOCAL
                                                          : SOD_OC_CALL_EXT_GLOBAL;
        nparams_o = 3'h2;
        kind0_o   = SOD_PK_UNSIGNED;
        kind1_o   = SOD_PK_UNSIGNED;
      end
      `SOD_OP_CALL_EXT_INTERM: begin
        opclass_o = SOD_OC_CALL_EXT_INTERM;
        nparams_o = 3'h3;
        kind0_o   = SOD_PK_UNSIGNED;
        kind1_o   = SOD_PK_DONT_CARE;
        kind2_o   = SOD_PK_UNSIGNED;
      end
      `SOD_OP_RETURN_USER_PROC: begin
        opclass_o = SOD_OC_RETURN_USER_PROC;
        nparams_o = 3'h1;
        kind0_o   = SOD_PK_BIG;
      end
      `SOD_OP_PUSH_STATIC_LINK: begin
        opclass_o = SOD_OC_PUSH_STATIC_LINK;
        nparams_o = 3'h1;
        kind0_o   = SOD_PK_DONT_CARE;
      end
      default: opclass_o = SOD_OC_ILLEGAL;
    endcase
  end

endmodule
`default_nettype wire

// ==== sod_param_widen.sv ====
// Purpose: Widen one or two parameter bytes into a word by parameter kind
// Assumes: Combinational; first byte is the one after the previous parameter
// Notes:   two_o tells whether the second byte is consumed
`timescale 1ns/1ps
`default_nettype none
`include "sod_regs.svh"

module sod_param_widen (
  // Bytes in
  input  wire sod_pkg::sod_pkind_t kind_i,
  input  wire logic [7:0]          first_i,
  input  wire logic [7:0]          second_i,
  // Word out
  output logic [15:0]              word_o,
  output logic                     two_o
);
  import sod_pkg::*;

  wire logic big_long = (first_i > `SOD_BIG_SHORT_LIMIT);

  always_comb begin
    word_o = `SOD_RESET_WORD;
    two_o  = 1'b0;
    case (kind_i)
      SOD_PK_SIGNED:    word_o = {{8{first_i[`SOD_SIGN_BIT]}}, first_i};
      SOD_PK_UNSIGNED,
      SOD_PK_DONT_CARE: word_o = {8'h00, first_i};
      SOD_PK_BIG: begin
        two_o  = big_long;
        word_o = big_long ? {1'b0, first_i[6:0], second_i} : {8'h00, first_i};
      end
      SOD_PK_WORD: begin
        two_o  = 1'b1;
        word_o = {second_i, first_i};
      end
      default: word_o = `SOD_RESET_WORD;
    endcase
  end

endmodule
`default_nettype wire

// ==== sod_fetch_model.sv ====
// Purpose: Behavioural fetch unit feeding the stack opcode decoder
// Assumes: Caller enters each task just after a falling edge
// Notes:   Idle bus shows the inverted last byte, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module sod_fetch_model (
  // Clock
  input  wire logic       core_clk_i,
  // Byte stream
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);

  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end

  // Byte is taken at the rising edge inside the wait
  task automatic put(input logic [7:0] b, input int gap);
    byte_valid_o = 1'b1;
    byte_o = b;
    @(negedge core_clk_i);
    if (gap > 0) begin
      byte_valid_o = 1'b0;
      byte_o = ~b;
    end
    repeat (gap) @(negedge core_clk_i);
  endtask

  task automatic idle();
    byte_valid_o = 1'b0;
    byte_o = ~byte_o;
  endtask

endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the stack opcode decoder
// Assumes: Inputs change at the falling edge, results read there too
// Notes:   All 256 opcode values are sent once, then boundary cases
`timescale 1ns/1ps
`default_nettype none
`include "sod_regs.svh"

module tb_top;
  import sod_pkg::*;

  typedef struct {
    logic [7:0]   op;
    sod_opclass_t cls;
    logic [2:0]   n;
    logic [11:0]  kinds;
    logic [15:0]  prm [4];
  } sod_exp_t;

  logic         core_clk_i;
  logic         nrst_i;
  logic         byte_valid;
  logic [7:0]   byte_d;
  logic         done_o;
  sod_opclass_t opclass_o;
  logic [7:0]   opcode_o;
  logic         illegal_o;
  logic         real_trap_en_o;
  logic [2:0]   nparams_o;
  logic [11:0]  kinds_o;
  logic [15:0]  param0_o;
  logic [15:0]  param1_o;
  logic [15:0]  param2_o;
  logic [15:0]  param3_o;
  logic         busy_o;
  logic [2:0]   pending_o;
  sod_pkind_t   next_kind_o;
  sod_exp_t     expq [$];
  sod_exp_t     mon_e;
  logic [7:0]   seed = 8'h16;
  int           n_fail = 0;
  int           checked = 0;

  sod_fetch_model u_sod_fetch_model (.core_clk_i, .byte_valid_o(byte_valid), .byte_o(byte_d));

  sod_decoder u_sod_decoder (
    .core_clk_i, .nrst_i, .byte_valid_i(byte_valid), .byte_i(byte_d), .done_o, .opclass_o,
    .opcode_o, .illegal_o, .real_trap_en_o, .nparams_o, .kinds_o, .param0_o, .param1_o,
    .param2_o, .param3_o, .busy_o, .pending_o, .next_kind_o
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic void lookup(input logic [7:0] op, output sod_opclass_t c,
                                 output sod_pkind_t k [3]);
    k = '{default: SOD_PK_NONE};
    case (op)
      `SOD_OP_UNSIGNED_LE:      c = SOD_OC_UNSIGNED_LE;
      `SOD_OP_UNSIGNED_GE:      c = SOD_OC_UNSIGNED_GE;
      `SOD_OP_INTEGER_ABSOLUTE: c = SOD_OC_INTEGER_ABSOLUTE;
      `SOD_OP_INTEGER_NEGATE:   c = SOD_OC_INTEGER_NEGATE;
      `SOD_OP_SUBRANGE_CHECK:   c = SOD_OC_SUBRANGE_CHECK;
      `SOD_OP_REAL_ADD:         c = SOD_OC_REAL_ADD;
      `SOD_OP_REAL_SUBTRACT:    c = SOD_OC_REAL_SUBTRACT;
      `SOD_OP_REAL_MULTIPLY:    c = SOD_OC_REAL_MULTIPLY;
      `SOD_OP_REAL_DIVIDE:      c = SOD_OC_REAL_DIVIDE;
      `SOD_OP_REAL_ABSOLUTE:    c = SOD_OC_REAL_ABSOLUTE;
      `SOD_OP_SET_SUBSET:       c = SOD_OC_SET_SUBSET;
      `SOD_OP_SET_SUPERSET:     c = SOD_OC_SET_SUPERSET;
      `SOD_OP_BYTES_EQUAL:      c = SOD_OC_BYTES_EQUAL;
      `SOD_OP_BYTES_LE:         c = SOD_OC_BYTES_LE;
      `SOD_OP_BYTES_GE:         c = SOD_OC_BYTES_GE;
      `SOD_OP_JUMP_ALWAYS:      c = SOD_OC_JUMP_ALWAYS;
      `SOD_OP_JUMP_FALSE_EQ:    c = SOD_OC_JUMP_FALSE_EQ;
      `SOD_OP_JUMP_FALSE_NE:    c = SOD_OC_JUMP_FALSE_NE;
      `SOD_OP_CALL_EXT_LOCAL:   c = SOD_OC_CALL_EXT_LOCAL;
      `SOD_OP_CALL_EXT_GLOBAL:  c = SOD_OC_CALL_EXT_GLOBAL;
      `SOD_OP_CALL_EXT_INTERM:  c = SOD_OC_CALL_EXT_INTERM;
      `SOD_OP_RETURN_USER_PROC: c = SOD_OC_RETURN_USER_PROC;
      `SOD_OP_PUSH_STATIC_LINK: c = SOD_OC_PUSH_STATIC_LINK;
      `SOD_OP_SWAP_TOP:         c = SOD_OC_SWAP_TOP;
      `SOD_OP_STORE_PACKED:     c = SOD_OC_STORE_PACKED;
      default:                  c = SOD_OC_ILLEGAL;
    endcase
    case (op)
      `SOD_OP_JUMP_ALWAYS, `SOD_OP_JUMP_FALSE_EQ, `SOD_OP_JUMP_FALSE_NE:
        k[0] = SOD_PK_SIGNED;
      `SOD_OP_BYTES_EQUAL, `SOD_OP_BYTES_LE, `SOD_OP_BYTES_GE:
        k[0] = SOD_PK_BIG;
      `SOD_OP_RETURN_USER_PROC: k[0] = SOD_PK_BIG;
      `SOD_OP_PUSH_STATIC_LINK: k[0] = SOD_PK_DONT_CARE;
      `SOD_OP_CALL_EXT_LOCAL, `SOD_OP_CALL_EXT_GLOBAL:
        k = '{SOD_PK_UNSIGNED, SOD_PK_UNSIGNED, SOD_PK_NONE};
      `SOD_OP_CALL_EXT_INTERM: k = '{SOD_PK_UNSIGNED, SOD_PK_DONT_CARE, SOD_PK_UNSIGNED};
      default: ;
    endcase
  endfunction

  // Builds the byte list and expected result, then streams it with random gaps
  task automatic run_instr(input logic [7:0] op, input logic [7:0] b0, b1, b2, b3,
                           input int gmax);
    sod_exp_t   e;
    sod_pkind_t k [3];
    logic [7:0] b [4];
    logic [7:0] s [$];
    int         j;
    b = '{b0, b1, b2, b3};
    j = 0;
    e.op = op;
    e.n = 3'h0;
    e.kinds = 12'h000;
    e.prm = '{default: 16'h0000};
    lookup(op, e.cls, k);
    s.push_back(op);
    for (int i = 0; i < 3; i++) begin
      if (k[i] != SOD_PK_NONE) begin
        e.n++;
        e.kinds[3*i +: 3] = k[i];
        // Fetch side never offers a don't-care byte above 127
        if (k[i] == SOD_PK_DONT_CARE) b[j][7] = 1'b0;
        if (k[i] == SOD_PK_SIGNED) e.prm[i] = {{8{b[j][7]}}, b[j]};
        else if (k[i] != SOD_PK_BIG || b[j] <= 8'h7F) e.prm[i] = {8'h00, b[j]};
        else begin
          e.prm[i] = {1'b0, b[j][6:0], b[j+1]};
          s.push_back(b[j]);
          j++;
        end
        s.push_back(b[j]);
        j++;
      end
    end
    expq.push_back(e);
    for (int i = 0; i < s.size(); i++) begin
      u_sod_fetch_model.put(s[i], (i + 1 < s.size()) ? int'(rnd()) % (gmax + 1) : 0);
      if (i == 0) begin
        chk("busy", 16'(busy_o), 16'(e.n != 3'h0));
        chk("pending", 16'(pending_o), 16'(e.n));
        if (e.n != 3'h0) chk("next_kind", 16'(next_kind_o), 16'(k[0]));
      end
    end
    chk("done", 16'(done_o), 16'h0001);
  endtask

  initial begin
    forever begin
      @(negedge core_clk_i);
      if (done_o === 1'b1) begin
        if (expq.size() == 0) chk("extra_done", 16'h0001, 16'h0000);
        else begin
          mon_e = expq.pop_front();
          chk("opcode", 16'(opcode_o), 16'(mon_e.op));
          chk("class", 16'(opclass_o), 16'(mon_e.cls));
          chk("illegal", 16'(illegal_o), 16'(mon_e.cls == SOD_OC_ILLEGAL));
          chk("real_trap", 16'(real_trap_en_o), 16'(mon_e.cls >= SOD_OC_REAL_ADD));
          chk("nparams", 16'(nparams_o), 16'(mon_e.n));
          chk("kinds", 16'(kinds_o), 16'(mon_e.kinds));
          chk("param0", param0_o, mon_e.prm[0]);
          chk("param1", param1_o, mon_e.prm[1]);
          chk("param2", param2_o, mon_e.prm[2]);
          chk("param3", param3_o, mon_e.prm[3]);
        end
      end
    end
  end

  initial begin
    nrst_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    chk("rst_busy", 16'(busy_o), 16'h0000);
    chk("rst_class", 16'(opclass_o), 16'h0000);
    nrst_i = 1'b1;
    for (int i = 0; i < 256; i++) begin
      run_instr(8'(i), rnd(), rnd(), rnd(), rnd(), 2);
    end
    run_instr(`SOD_OP_RETURN_USER_PROC, 8'h7F, 8'h55, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_BYTES_GE, 8'h80, 8'h01, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_BYTES_LE, 8'hFF, 8'hFF, 8'h00, 8'h00, 1);
    run_instr(`SOD_OP_JUMP_FALSE_NE, 8'h80, 8'h00, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_JUMP_ALWAYS, 8'h7F, 8'h00, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_JUMP_ALWAYS, 8'hFE, 8'h00, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_CALL_EXT_GLOBAL, 8'h12, 8'hC4, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_RETURN_USER_PROC, 8'h81, 8'h23, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_SWAP_TOP, 8'h00, 8'h00, 8'h00, 8'h00, 0);
    run_instr(`SOD_OP_SWAP_TOP, 8'h00, 8'h00, 8'h00, 8'h00, 0);
    // Reset in mid-instruction must drop the half-collected call
    u_sod_fetch_model.put(`SOD_OP_CALL_EXT_INTERM, 0);
    u_sod_fetch_model.put(8'h05, 0);
    u_sod_fetch_model.idle();
    nrst_i = 1'b0;
    @(negedge core_clk_i);
    chk("mid_rst_busy", 16'(busy_o), 16'h0000);
    chk("mid_rst_pending", 16'(pending_o), 16'h0000);
    nrst_i = 1'b1;
    run_instr(`SOD_OP_CALL_EXT_INTERM, 8'h01, 8'h7F, 8'hFE, 8'h00, 1);
    u_sod_fetch_model.idle();
    repeat (3) @(negedge core_clk_i);
    chk("queue_left", 16'(expq.size()), 16'h0000);
    close_out();
  end

  // Whole run is about 330 cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    close_out();
  end

endmodule

`default_nettype wire
